// ---- logic/aur_params.svh ----
// Purpose: constants for the asynchronous receiver
// Assumes: included by bare name
// Notes:   offsets are byte addresses on the register bus
`ifndef AUR_PARAMS_SVH
`define AUR_PARAMS_SVH
`define AUR_OFF_CTRL     12'h000
`define AUR_OFF_STATUS   12'h004
`define AUR_OFF_DATA     12'h008
`define AUR_OFF_BAUD     12'h00c
`define AUR_OFF_IRQEN    12'h010
`define AUR_CTRL_SERIAL_PORT_ENABLE    0
`define AUR_CTRL_CONTINUOUS_RECEIVE_ENABLE    1
`define AUR_CTRL_SYNC    2
`define AUR_CTRL_RX9     3
`define AUR_CTRL_ADDRESS_DETECT_ENABLE   4
`define AUR_ST_FLAG      0
`define AUR_ST_FRAMING_ERROR_STATUS      1
`define AUR_ST_OVERRUN_ERROR_STATUS      2
`define AUR_ST_NINTH     3
`define AUR_ST_IDLE      4
`define AUR_ST_IRQ       5
`define AUR_IE_RCIE      0
`define AUR_IE_PERIPHERAL_IRQ_ENABLE      1
`define AUR_IE_GIE       2
`define AUR_OVERSAMPLE   16
`define AUR_HALF_TICKS   8
`define AUR_BAUD_RESET   16'h0001
`define AUR_RESP_OKAY    2'b00
`define AUR_RESP_SLVERR  2'b10
`endif

// ---- logic/aur_pkg.sv ----
// Purpose: types for the asynchronous receiver
// Assumes: nothing
// Notes:   constants live in aur_params.svh
`default_nettype none
package aur_pkg;
   typedef enum logic [1:0] {
      AUR_IDLE  = 2'b00,
      AUR_START = 2'b01,
      AUR_DATA  = 2'b10,
      AUR_STOP  = 2'b11
   } aur_state_t;
endpackage
`default_nettype wire

// ---- logic/aur_fifo_if.sv ----
// Purpose: push/pop carrier between receiver core and character fifo
// Assumes: one clock
// Notes:   entry is nine data bits and a framing error bit
`default_nettype none
interface aur_fifo_if;
   logic       push;
   logic [8:0] push_data;
   logic       push_framing_error_status;
   logic       pop;
   logic       clear;
   logic [1:0] count;
   logic [8:0] top_data;
   logic       top_framing_error_status;
   modport owner (output push, push_data, push_framing_error_status, pop, clear,
                  input count, top_data, top_framing_error_status);
   modport store (input push, push_data, push_framing_error_status, pop, clear,
                  output count, top_data, top_framing_error_status);
endinterface
`default_nettype wire

// ---- logic/aur_fifo.sv ----
// Purpose: two-entry character fifo with per-entry framing error
// Assumes: owner pushes into a full fifo only together with a pop
// Notes:   storage is flip-flops indexed by read pointer
`default_nettype none
module aur_fifo #(
   parameter int DEPTH = 2
) (
   input  wire logic   aclk,     // system clock
   input  wire logic   aresetn,  // synchronous reset, active low
   aur_fifo_if.store   f         // push/pop side
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH != 2) $error("aur_fifo: depth must be 2");
   end
   logic [9:0]    mem_reg [DEPTH];
   logic [AW-1:0] rd_reg;
   logic [1:0]    cnt_reg;
   logic [AW-1:0] wr_idx;

   assign wr_idx     = rd_reg + AW'(cnt_reg);
   assign f.count    = cnt_reg;
   assign f.top_data = mem_reg[rd_reg][8:0];
   assign f.top_framing_error_status = mem_reg[rd_reg][9];

   // storage write; contents need no reset since count guards them
   always_ff @(posedge aclk) begin
      if (f.push) begin
         mem_reg[wr_idx] <= {f.push_framing_error_status, f.push_data};
      end
   end

   // pointers; pop of an empty fifo is ignored
   always_ff @(posedge aclk) begin
      if (!aresetn || f.clear) begin
         rd_reg  <= '0;
         cnt_reg <= 2'h0;
      end else begin
         if (f.pop && cnt_reg != 2'h0) begin
            rd_reg <= rd_reg + AW'(1);
         end
         cnt_reg <= cnt_reg + 2'(f.push) - 2'(f.pop && cnt_reg != 2'h0);
      end
   end
endmodule
`default_nettype wire

// ---- logic/aur_rx.sv ----
// Summary of operation
// - falling edge starts a character; start centre checked low after half bit
// - high start centre drops the attempt silently, back to edge watching
// - each data bit taken one bit time later by majority, shifted in
// - stop bit sampled one bit later; low means framing error
// - finished character moves to the fifo at once
// - data register read returns oldest character and pops it
// - receive flag high when enabled and fifo not empty; read only
// - flag follows occupancy; irq needs all three enables
// - framing error stored per entry; status shows the oldest only
// - framing error never stops reception nor raises an irq
// - port disable resets and clears framing error; receive disable keeps it
// - all-errored fifo keeps framing status set across reads
// - two-character fifo; third complete character sets overrun
// - under overrun fifo stays readable, nothing new accepted
// - overrun clears only by receive disable, port disable or sync mode set
// - nine-bit mode shifts nine bits; ninth bit readable in status
// - address detect in nine-bit mode keeps only characters with ninth bit set
// - line sampled at sixteen times baud; shifting at bit rate
// - characters assembled least significant bit first
//
// Purpose: asynchronous serial receiver with AXI4-Lite registers
// Assumes: 32-bit AXI4-Lite master, one write and one read at a time
// Notes:   baud tick = aclk / (divisor+1) gives the 16x sample rate
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`include "aur_params.svh"
`default_nettype none
module aur_rx #(
   parameter int DIV_W = 16
) (
   input  wire logic        aclk,            // system clock, 250 MHz
   input  wire logic        aresetn,         // synchronous reset, active low
   input  wire logic [11:0] s_axi_awaddr,    // write address
   input  wire logic        s_axi_awvalid,   // write address valid
   output var  logic        s_axi_awready,   // write address ready
   input  wire logic [31:0] s_axi_wdata,     // write data
   input  wire logic [3:0]  s_axi_wstrb,     // write strobes
   input  wire logic        s_axi_wvalid,    // write data valid
   output var  logic        s_axi_wready,    // write data ready
   output var  logic [1:0]  s_axi_bresp,     // write response
   output var  logic        s_axi_bvalid,    // write response valid
   input  wire logic        s_axi_bready,    // write response ready
   input  wire logic [11:0] s_axi_araddr,    // read address
   input  wire logic        s_axi_arvalid,   // read address valid
   output var  logic        s_axi_arready,   // read address ready
   output var  logic [31:0] s_axi_rdata,     // read data
   output var  logic [1:0]  s_axi_rresp,     // read response
   output var  logic        s_axi_rvalid,    // read data valid
   input  wire logic        s_axi_rready,    // read data ready
   input  wire logic        serial_receive_pin, // asynchronous line in
   output var  logic        receive_irq      // interrupt request
);
   initial begin
      if (DIV_W < 8 || DIV_W > 16) $error("aur_rx: DIV_W must be 8..16");
   end

   // control registers
   logic             serial_port_enable_reg;
   logic             continuous_receive_enable_reg;
   logic             sync_mode_reg;
   logic             nine_bit_receive_enable_reg;
   logic             address_detect_enable_reg;
   logic             receive_irq_enable_reg;
   logic             peripheral_irq_enable_reg;
   logic             global_irq_enable_reg;
   logic [DIV_W-1:0] baud_div_reg;
   logic             overrun_error_status_reg;

   // bus state
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;

   // receiver state
   aur_pkg::aur_state_t state_reg;
   logic [DIV_W-1:0]    div_cnt_reg;
   logic [3:0]          tick_cnt_reg;
   logic [3:0]          bit_cnt_reg;
   logic [8:0]          receive_shift_register_reg;
   logic [2:0]          samp_reg;
   logic                sync1_reg;
   logic                sync2_reg;
   logic                line_prev_reg;

   logic tick;
   logic rx_on;
   logic majority;
   logic read_go;
   logic data_read;
   logic done_push;
   logic [3:0] nbits;
   logic [31:0] rd_word;

   aur_fifo_if fif ();

   aur_fifo #(
      .DEPTH (2)
   ) u_fifo (
      .aclk    (aclk),
      .aresetn (aresetn),
      .f       (fif.store)
   );

   assign rx_on = serial_port_enable_reg && continuous_receive_enable_reg
                  && !sync_mode_reg;
   assign nbits = nine_bit_receive_enable_reg ? 4'h9 : 4'h8;

   // ---------------- AXI4-Lite write side ----------------
   // the write lands once both halves are held and no response is pending,
   // so address and data may arrive in either order

   // capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         aw_addr_reg   <= 12'h000;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_held_reg && w_held_reg) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
         end
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AUR_RESP_OKAY;
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) s_axi_bvalid <= 1'b0;
      end else if (aw_held_reg && w_held_reg) begin
         s_axi_bvalid <= 1'b1;
         unique case (aw_addr_reg)
            `AUR_OFF_CTRL, `AUR_OFF_BAUD, `AUR_OFF_IRQEN: s_axi_bresp <= `AUR_RESP_OKAY;
            `AUR_OFF_STATUS, `AUR_OFF_DATA:               s_axi_bresp <= `AUR_RESP_OKAY;
            default:                                      s_axi_bresp <= `AUR_RESP_SLVERR;
         endcase
      end
   end

   // register writes; status and data are read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_port_enable_reg        <= 1'b0;
         continuous_receive_enable_reg <= 1'b0;
         sync_mode_reg                 <= 1'b0;
         nine_bit_receive_enable_reg   <= 1'b0;
         address_detect_enable_reg     <= 1'b0;
         receive_irq_enable_reg        <= 1'b0;
         peripheral_irq_enable_reg     <= 1'b0;
         global_irq_enable_reg         <= 1'b0;
         baud_div_reg                  <= DIV_W'(`AUR_BAUD_RESET);
      end else if (aw_held_reg && w_held_reg && !s_axi_bvalid && w_strb_reg[0]) begin
         unique case (aw_addr_reg)
            `AUR_OFF_CTRL: begin
               serial_port_enable_reg        <= w_data_reg[`AUR_CTRL_SERIAL_PORT_ENABLE];
               continuous_receive_enable_reg <= w_data_reg[`AUR_CTRL_CONTINUOUS_RECEIVE_ENABLE];
               sync_mode_reg                 <= w_data_reg[`AUR_CTRL_SYNC];
               nine_bit_receive_enable_reg   <= w_data_reg[`AUR_CTRL_RX9];
               address_detect_enable_reg     <= w_data_reg[`AUR_CTRL_ADDRESS_DETECT_ENABLE];
            end
            `AUR_OFF_IRQEN: begin
               receive_irq_enable_reg    <= w_data_reg[`AUR_IE_RCIE];
               peripheral_irq_enable_reg <= w_data_reg[`AUR_IE_PERIPHERAL_IRQ_ENABLE];
               global_irq_enable_reg     <= w_data_reg[`AUR_IE_GIE];
            end
            `AUR_OFF_BAUD: begin
               baud_div_reg[7:0] <= w_data_reg[7:0];
               if (w_strb_reg[1] && DIV_W > 8) begin
                  baud_div_reg <= w_data_reg[DIV_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------- AXI4-Lite read side ----------------
   assign read_go   = s_axi_arvalid && s_axi_arready;
   assign data_read = read_go && s_axi_araddr == `AUR_OFF_DATA;

   // status reflects only the oldest entry
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr)
         `AUR_OFF_CTRL: begin
            rd_word[`AUR_CTRL_SERIAL_PORT_ENABLE]  = serial_port_enable_reg;
            rd_word[`AUR_CTRL_CONTINUOUS_RECEIVE_ENABLE]  = continuous_receive_enable_reg;
            rd_word[`AUR_CTRL_SYNC]  = sync_mode_reg;
            rd_word[`AUR_CTRL_RX9]   = nine_bit_receive_enable_reg;
            rd_word[`AUR_CTRL_ADDRESS_DETECT_ENABLE] = address_detect_enable_reg;
         end
         `AUR_OFF_STATUS: begin
            rd_word[`AUR_ST_FLAG]  = fif.count != 2'h0;
            rd_word[`AUR_ST_FRAMING_ERROR_STATUS]  = fif.count != 2'h0 && fif.top_framing_error_status;
            rd_word[`AUR_ST_OVERRUN_ERROR_STATUS]  = overrun_error_status_reg;
            rd_word[`AUR_ST_NINTH] = fif.count != 2'h0 && fif.top_data[8];
            rd_word[`AUR_ST_IDLE]  = state_reg == aur_pkg::AUR_IDLE;
            rd_word[`AUR_ST_IRQ]   = receive_irq;
         end
         `AUR_OFF_DATA:  rd_word[7:0] = fif.top_data[7:0];
         `AUR_OFF_BAUD:  rd_word[DIV_W-1:0] = baud_div_reg;
         `AUR_OFF_IRQEN: begin
            rd_word[`AUR_IE_RCIE] = receive_irq_enable_reg;
            rd_word[`AUR_IE_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_reg;
            rd_word[`AUR_IE_GIE]  = global_irq_enable_reg;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // read address accepted one cycle after valid, data the cycle after
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `AUR_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (read_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            unique case (s_axi_araddr)
               `AUR_OFF_CTRL, `AUR_OFF_STATUS, `AUR_OFF_DATA,
               `AUR_OFF_BAUD, `AUR_OFF_IRQEN: s_axi_rresp <= `AUR_RESP_OKAY;
               default:                        s_axi_rresp <= `AUR_RESP_SLVERR;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // interrupt request needs flag and all three enables; framing errors never count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_irq <= 1'b0;
      end else begin
         receive_irq <= fif.count != 2'h0 && receive_irq_enable_reg
                        && peripheral_irq_enable_reg && global_irq_enable_reg;
      end
   end

   // ---------------- line sampling ----------------
   // two flops against metastability; the line idles high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg     <= 1'b1;
         sync2_reg     <= 1'b1;
         line_prev_reg <= 1'b1;
      end else begin
         sync1_reg     <= serial_receive_pin;
         sync2_reg     <= sync1_reg;
         line_prev_reg <= sync2_reg;
      end
   end

   // 16x baud tick divider, restarted while the port is off
   assign tick = div_cnt_reg == '0;
   always_ff @(posedge aclk) begin
      if (!aresetn || !serial_port_enable_reg) begin
         div_cnt_reg <= '0;
      end else begin
         div_cnt_reg <= tick ? baud_div_reg : div_cnt_reg - DIV_W'(1);
      end
   end

   // three samples on the ticks just before and at each centre
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samp_reg <= 3'h7;
      end else if (tick) begin
         samp_reg <= {samp_reg[1:0], sync2_reg};
      end
   end
   assign majority = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & samp_reg[2])
                     | (samp_reg[1] & samp_reg[2]);

   // ---------------- receive sequencer ----------------
   // a sample lag of one tick is absorbed: the centre is the tick count reaching the mark
   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_on) begin
         state_reg    <= aur_pkg::AUR_IDLE;
         tick_cnt_reg <= 4'h0;
         bit_cnt_reg  <= 4'h0;
         receive_shift_register_reg <= 9'h000;
      end else begin
         unique case (state_reg)
            aur_pkg::AUR_IDLE: begin
               tick_cnt_reg <= 4'h0;
               if (line_prev_reg && !sync2_reg && !overrun_error_status_reg) begin
                  state_reg <= aur_pkg::AUR_START;
               end
            end
            aur_pkg::AUR_START: if (tick) begin
               tick_cnt_reg <= tick_cnt_reg + 4'h1;
               if (tick_cnt_reg == 4'(`AUR_HALF_TICKS - 1)) begin
                  tick_cnt_reg <= 4'h0;
                  bit_cnt_reg  <= 4'h0;
                  state_reg <= majority ? aur_pkg::AUR_IDLE
                                        : aur_pkg::AUR_DATA;
               end
            end
            aur_pkg::AUR_DATA: if (tick) begin
               tick_cnt_reg <= tick_cnt_reg + 4'h1;
               if (tick_cnt_reg == 4'(`AUR_OVERSAMPLE - 1)) begin
                  // lsb first: shift right, top bit lands by position
                  receive_shift_register_reg <= nine_bit_receive_enable_reg
                     ? {majority, receive_shift_register_reg[8:1]}
                     : {1'b0, majority, receive_shift_register_reg[7:1]};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == nbits - 4'h1) state_reg <= aur_pkg::AUR_STOP;
               end
            end
            aur_pkg::AUR_STOP: if (tick) begin
               tick_cnt_reg <= tick_cnt_reg + 4'h1;
               if (tick_cnt_reg == 4'(`AUR_OVERSAMPLE - 1)) begin
                  state_reg <= aur_pkg::AUR_IDLE;
               end
            end
         endcase
      end
   end

   // stop centre reached: hand the character over in the same cycle
   assign done_push = rx_on && tick && state_reg == aur_pkg::AUR_STOP
                      && tick_cnt_reg == 4'(`AUR_OVERSAMPLE - 1)
                      && !(nine_bit_receive_enable_reg && address_detect_enable_reg
                           && !receive_shift_register_reg[8])
                      && !overrun_error_status_reg;

   // a pop in the same cycle frees the slot, so a full fifo still takes it
   assign fif.push      = done_push && (fif.count != 2'h2 || data_read);
   assign fif.push_data = receive_shift_register_reg;
   assign fif.push_framing_error_status = !majority;
   assign fif.pop       = data_read;
   assign fif.clear     = !serial_port_enable_reg;

   // overrun: third full character with fifo full; only enables or sync mode clear it
   always_ff @(posedge aclk) begin
      if (!aresetn || !rx_on) begin
         overrun_error_status_reg <= 1'b0;
      end else if (done_push && fif.count == 2'h2 && !data_read) begin
         overrun_error_status_reg <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- tb/aur_rx_sva.sv ----
// Purpose: port-level protocol and interrupt checks for the receiver
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto every aur_rx instance
`include "aur_params.svh"
`default_nettype none
module aur_rx_sva (
   input wire logic        aclk,          // system clock
   input wire logic        aresetn,       // reset, active low
   input wire logic        s_axi_awvalid, // write address valid
   input wire logic        s_axi_awready, // write address ready
   input wire logic        s_axi_wvalid,  // write data valid
   input wire logic        s_axi_wready,  // write data ready
   input wire logic        s_axi_bvalid,  // write response valid
   input wire logic        s_axi_bready,  // write response ready
   input wire logic        s_axi_arvalid, // read address valid
   input wire logic        s_axi_arready, // read address ready
   input wire logic [31:0] s_axi_rdata,   // read data
   input wire logic [1:0]  s_axi_rresp,   // read response
   input wire logic        s_axi_rvalid,  // read data valid
   input wire logic        s_axi_rready,  // read data ready
   input wire logic        receive_irq    // interrupt request
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic       acc;        // an address was taken this cycle
   logic [3:0] since_reg;  // clocks since the last address handshake
   assign acc = (s_axi_arvalid && s_axi_arready) || (s_axi_awvalid && s_axi_awready);
   // saturating count, so a dropped irq can be tied to a recent access
   always_ff @(posedge aclk) begin
      if (!aresetn) since_reg <= 4'hf;
      else if (acc) since_reg <= 4'h0;
      else if (since_reg != 4'hf) since_reg <= since_reg + 4'h1;
   end
   // handshake steps
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped before bready");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
                                     |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed before rready");
   chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("rvalid late after read address");
   chk_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
      else $error("bvalid late after write");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `AUR_RESP_SLVERR
                                     |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   chk_irq_fall_cause: assert property ($fell(receive_irq) |-> since_reg < 4'h8)
      else $error("irq dropped without a register access");
endmodule
bind aur_rx aur_rx_sva chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .receive_irq);
`default_nettype wire

// ---- tb/aur_tx_model.sv ----
// Purpose: remote transmitter driving the receive line
// Assumes: bit time given by BIT_NS
// Notes:   line rests high between frames, as a pulled-up wire would
`default_nettype none
module aur_tx_model #(
   parameter int BIT_NS = 128
) (
   output var logic line  // serial line to the receiver
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line = 1'b1;
   // one frame: start, data lsb first, stop, one idle bit
   // non-blocking updates keep the line change clear of the sampling edge
   task automatic send(input logic [8:0] d, input logic nine, input logic stop);
      line <= 1'b0;
      #(BIT_NS);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
         line <= d[i];
         #(BIT_NS);
      end
      line <= stop;  // low only where a framing error is wanted
      #(BIT_NS);
      line <= 1'b1;
      #(BIT_NS);
   endtask
   // short low blip, too short to be a start bit
   task automatic glitch();
      line <= 1'b0;
      #(BIT_NS / 4);
      line <= 1'b1;
      #(BIT_NS);
   endtask
endmodule
`default_nettype wire

// ---- tb/aur_rx_test.sv ----
// Purpose: self-checking bench for the asynchronous receiver
// Assumes: baud divisor 1, so one bit lasts 32 clocks
// Notes:   status bit 4 (idle) is masked out of comparisons
`include "aur_params.svh"
`default_nettype none
module aur_rx_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        serial_receive_pin, receive_irq;
   int          n_fail = 0;
   int          samples_checked = 0;
   always #2 aclk = ~aclk;  // 250 MHz
   aur_rx dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .serial_receive_pin, .receive_irq);
   aur_tx_model #(.BIT_NS(128)) tx (.line(serial_receive_pin));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one write; ready is raised only after bvalid, so the slave must hold it
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bready && s_axi_bvalid) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
   endtask
   // one read; data and response land in d and rsp
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rready && s_axi_rvalid) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic st(input logic [31:0] e);
      rd(`AUR_OFF_STATUS);
      cmp(d & 32'h0000002f, e);
   endtask
   task automatic dat(input logic [31:0] e);
      rd(`AUR_OFF_DATA);
      cmp(d & 32'h000000ff, e);
   endtask
   task automatic t_basic();
      tx.glitch();
      tx.send(9'h0a5, 1'b0, 1'b1);
      st(32'h21);
      cmp({31'h0, receive_irq}, 32'h1);
      dat(32'ha5);
      st(32'h00);
      rd(12'hff0);
      cmp({30'h0, rsp}, {30'h0, `AUR_RESP_SLVERR});
      $display("basic test done");
   endtask
   task automatic t_errors();
      tx.send(9'h011, 1'b0, 1'b0);
      tx.send(9'h022, 1'b0, 1'b0);
      tx.send(9'h033, 1'b0, 1'b1);
      st(32'h27);
      dat(32'h11);
      st(32'h27);
      dat(32'h22);
      tx.send(9'h044, 1'b0, 1'b1);
      st(32'h04);
      wr(`AUR_OFF_CTRL, 32'h1);
      wr(`AUR_OFF_CTRL, 32'h3);
      st(32'h00);
      tx.send(9'h055, 1'b0, 1'b0);
      st(32'h23);
      wr(`AUR_OFF_CTRL, 32'h1);
      tx.send(9'h066, 1'b0, 1'b1);
      st(32'h23);
      wr(`AUR_OFF_CTRL, 32'h0);
      st(32'h00);
      $display("error test done");
   endtask
   task automatic t_nine();
      wr(`AUR_OFF_CTRL, 32'h1b);
      tx.send(9'h055, 1'b1, 1'b1);
      tx.send(9'h1aa, 1'b1, 1'b1);
      st(32'h29);
      dat(32'haa);
      wr(`AUR_OFF_CTRL, 32'h0b);
      tx.send(9'h055, 1'b1, 1'b1);
      st(32'h21);
      dat(32'h55);
      $display("nine-bit test done");
   endtask
   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // main sequence: idle bus, reset, configure, scenarios
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      s_axi_wstrb = 4'hf;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wr(`AUR_OFF_BAUD, 32'h1);
      wr(`AUR_OFF_IRQEN, 32'h7);
      wr(`AUR_OFF_CTRL, 32'h3);
      t_basic();
      t_errors();
      wr(`AUR_OFF_CTRL, 32'h3);
      t_nine();
      end_sim();
   end
   // watchdog: scenarios need about 15 us
   initial begin
      #100000;
      n_fail++;
      $display("ERROR %0t timeout", $time);
      end_sim();
   end
endmodule
`default_nettype wire
